// File: dv/nvm_array_model.sv
// array model: data eeprom cells and flash program words behind the controller
`timescale 1ns/1ps
`default_nettype none
module nvm_array_model (
    // clock
    input  wire logic        clk_sys,
    // eeprom side
    input  wire logic [7:0]  eeAddr,
    input  wire logic [7:0]  eeWrData,
    input  wire logic        eeWrEn,
    output logic [7:0]       eeRdData,
    // flash side
    input  wire logic [15:0] flashAddr,
    input  wire logic        flashRdEn,
    output logic [15:0]      flashRdData
);
    logic [7:0]  mem [256];
    logic [15:0] word;

    // seeded cells, so a read of an unwritten byte is not simply zero
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3C;
    always @(posedge clk_sys) if (eeWrEn === 1'b1) mem[eeAddr] <= eeWrData;
    assign eeRdData = mem[eeAddr];

    // word only valid in the access slot; inverted elsewhere so a wrong slot shows
    assign word        = {flashAddr[7:0], flashAddr[15:8]} ^ 16'h5A3C;
    assign flashRdData = flashRdEn ? word : ~word;
endmodule
`default_nettype wire

// File: dv/nvm_self_access_controller_bench.sv
// testbench: register level checks of the nvm self-access controller
`timescale 1ns/1ps
`default_nettype none
module nvm_self_access_controller_bench import nvm_pkg::*;;
    logic        clk_sys, eeWrEn, flashRdEn, nvmIrq, awready, wready, bvalid, arready, rvalid;
    logic        rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic        bready = 1'b1, rready = 1'b1;
    logic [3:0]  wstrb = 4'hF;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, eeAddr, eeWrData, eeRdData;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    logic [15:0] flashAddr, flashRdData;
    logic [7:0]  shadow [256];
    int          fails = 0, n_checks = 0, nWr = 0, nFl = 0;

    nvm_self_access_controller u_dut (.clk_sys, .rst_b, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .eeAddr, .eeWrData, .eeWrEn, .eeRdData, .flashAddr,
        .flashRdEn, .flashRdData, .nvmIrq);
    nvm_array_model u_mem (.clk_sys, .eeAddr, .eeWrData, .eeWrEn, .eeRdData, .flashAddr,
        .flashRdEn, .flashRdData);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // count array strobes to see exactly one per accepted operation
    always @(posedge clk_sys) begin
        if (eeWrEn === 1'b1) nWr++;
        if (flashRdEn === 1'b1) nFl++;
    end
    // whole-run limit
    initial begin
        repeat (50000) @(posedge clk_sys);
        fails++;
        finish_test();
    end

    // ------------------------------------------------------------
    // bus tasks and compares
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic guard(input logic ok);
        if (ok !== 1'b1) begin
            fails++;
            $display("wrong value handshake expected 1 seen %b", ok);
            finish_test();
        end
    endtask
    // ready is looked at mid-cycle; the handshake lands at the next rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        logic pa, pd, tb;
        logic [1:0] r;
        tb = 1'b0;
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        for (int k = 0; k < 60 && !tb; k++) begin
            @(negedge clk_sys);
            pa = awvalid & awready;
            pd = wvalid & wready;
            tb = bvalid;
            r  = bresp;
            @(posedge clk_sys);
            if (pa) awvalid <= 1'b0;
            if (pd) wvalid <= 1'b0;
        end
        guard(tb);
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        logic pa, tr;
        logic [1:0] r;
        tr = 1'b0;
        araddr  <= a;
        arvalid <= 1'b1;
        for (int k = 0; k < 60 && !tr; k++) begin
            @(negedge clk_sys);
            pa = arvalid & arready;
            tr = rvalid;
            d  = rdata;
            r  = rresp;
            @(posedge clk_sys);
            if (pa) arvalid <= 1'b0;
        end
        guard(tr);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask
    task automatic expect_reg(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(nm, {24'h0, e}, v);
    endtask
    // m: 0 clean sequence, 1 read between keys, 2 keys swapped
    task automatic ee_write(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c,
                            input int m);
        logic [31:0] v;
        wr(OFS_ADDR_LO, a);
        wr(OFS_VAL_LO, d);
        wr(OFS_CTRL, c & 8'hFD);
        wr(OFS_UNLOCK, m == 2 ? KEY_SECOND : KEY_FIRST);
        if (m == 1) rd(OFS_ADDR_LO, v);
        wr(OFS_UNLOCK, m == 2 ? KEY_FIRST : KEY_SECOND);
        wr(OFS_CTRL, c);
    endtask
    task automatic ee_check(input logic [7:0] a);
        wr(OFS_ADDR_LO, a);
        wr(OFS_CTRL, 8'h01);
        expect_reg("eeprom byte", OFS_VAL_LO, shadow[a]);
        expect_reg("byte held", OFS_VAL_LO, shadow[a]);
    endtask
    task automatic wait_idle();
        logic [31:0] v;
        v = 32'h2;
        for (int k = 0; k < 40 && v[CTL_WR] !== 1'b0; k++) rd(OFS_CTRL, v);
        guard(v[CTL_WR] === 1'b0);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0]  a, d, c;
        logic [15:0] fa, w;
        logic [31:0] v;
        int          n0;
        for (int i = 0; i < 256; i++) shadow[i] = 8'(i) ^ 8'h3C;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        void'($urandom(30932));
        for (int i = 0; i <= 6; i++) expect_reg("reset value", 8'(4 * i), RST_BYTE);
        $display("test reset done");
        // accepted writes, each read back through the eeprom read path
        for (int i = 0; i < 4; i++) begin
            a = 8'($urandom);
            d = 8'($urandom);
            n0 = nWr;
            ee_write(a, d, 8'h06, 0);
            expect_reg("start held", OFS_CTRL, 8'h06);
            wait_idle();
            chk("one array write", n0 + 1, nWr);
            expect_reg("permit kept", OFS_CTRL, 8'h04);
            expect_reg("done set", OFS_IRQ, 8'h01);
            wr(OFS_IRQ, 8'h00);
            expect_reg("done cleared", OFS_IRQ, 8'h00);
            wr(OFS_CTRL, 8'h00);
            shadow[a] = d;
            ee_check(a);
            ee_check(8'($urandom));
        end
        $display("test eeprom write done");
        // refused starts: permit clear, program space, broken and swapped keys
        for (int i = 0; i < 4; i++) begin
            c = i == 0 ? 8'h02 : (i == 1 ? 8'h86 : 8'h06);
            n0 = nWr;
            ee_write(8'($urandom), 8'($urandom), c, i < 2 ? 0 : i - 1);
            expect_reg("start refused", OFS_CTRL, c & 8'hFD);
            repeat (20) @(posedge clk_sys);
            chk("no array write", n0, nWr);
            expect_reg("no done", OFS_IRQ, 8'h00);
            wr(OFS_CTRL, 8'h00);
        end
        $display("test refused start done");
        // permit dropped and a second unlock attempted while the write runs
        wr(OFS_IRQ, 8'h06);
        a = 8'($urandom);
        d = 8'($urandom);
        n0 = nWr;
        ee_write(a, d, 8'h06, 0);
        wr(OFS_CTRL, 8'h00);
        wr(OFS_UNLOCK, KEY_FIRST);
        wr(OFS_UNLOCK, KEY_SECOND);
        wr(OFS_CTRL, 8'h06);
        wait_idle();
        chk("irq on done", 32'h1, {31'h0, nvmIrq});
        chk("single write", n0 + 1, nWr);
        shadow[a] = d;
        ee_check(a);
        // completion interrupt needs enable and gate
        wr(OFS_IRQ, 8'h03);
        chk("irq no gate", 32'h0, {31'h0, nvmIrq});
        wr(OFS_IRQ, 8'h07);
        chk("irq raised", 32'h1, {31'h0, nvmIrq});
        wr(OFS_IRQ, 8'h06);
        chk("irq cleared", 32'h0, {31'h0, nvmIrq});
        wr(OFS_CTRL, 8'h00);
        $display("test busy and irq done");
        // flash reads: word lands in both value registers
        for (int i = 0; i < 3; i++) begin
            fa = 16'($urandom);
            w = {fa[7:0], fa[15:8]} ^ 16'h5A3C;
            n0 = nFl;
            wr(OFS_ADDR_LO, fa[7:0]);
            wr(OFS_ADDR_HI, fa[15:8]);
            wr(OFS_CTRL, 8'h81);
            repeat (2) @(posedge clk_sys);
            expect_reg("word low", OFS_VAL_LO, w[7:0]);
            expect_reg("word high", OFS_VAL_HI, w[15:8]);
            chk("one access slot", n0 + 1, nFl);
            expect_reg("read start clear", OFS_CTRL, 8'h80);
        end
        $display("test flash read done");
        // a write with the low lane strobe off must leave the register alone
        wstrb <= 4'hE;
        wr(OFS_ADDR_HI, ~fa[15:8]);
        wstrb <= 4'hF;
        expect_reg("lane off", OFS_ADDR_HI, fa[15:8]);
        wr(8'h1C, 8'h5A, RESP_SLVERR);
        rd(8'h22, v, RESP_SLVERR);
        chk("unmapped data", 32'h0, v);
        $display("test unmapped done");
        finish_test();
    end
endmodule
`default_nettype wire

// File: hw/nvm_pkg.sv
// package: register map, field layout and timing of the nvm self-access controller
// Function
// - eeprom read: load low address, select data space, set read-start; byte next cycle
// - value low keeps the last read byte until next read or software write
// - each write needs 55h then AAh to the unlock port, then write-start
// - write-start cannot become set while modify permit is clear
// - only software changes modify permit; completion leaves it alone
// - a started write runs to its end even if permit is cleared
// - at write end, write-start clears and the done flag sets
// - hardware never clears the done flag; software clears it after each write
// - flash read: load both address bytes, select program space, set read-start
// - flash read uses the second cycle after read-start; the first cycle after it is discarded
// - flash word lands in value low and high and holds until next read or software write
// - write-start with program space selected is dropped at once, nothing happens
// - completion interrupt needs the peripheral gate as well as its own enable
package nvm_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_ADDR_LO = 8'h00;
    localparam logic [7:0] OFS_ADDR_HI = 8'h04;
    localparam logic [7:0] OFS_VAL_LO  = 8'h08;
    localparam logic [7:0] OFS_VAL_HI  = 8'h0C;
    localparam logic [7:0] OFS_CTRL    = 8'h10;
    localparam logic [7:0] OFS_UNLOCK  = 8'h14;
    localparam logic [7:0] OFS_IRQ     = 8'h18;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL_RD     = 0;
    localparam int CTL_WR     = 1;
    localparam int CTL_PERMIT = 2;
    localparam int CTL_PSS    = 7;
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_EN     = 1;
    localparam int IRQ_GATE   = 2;

    // ------------------------------------------------------------
    // reset values, keys, timing, responses
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [7:0] KEY_FIRST    = 8'h55;
    localparam logic [7:0] KEY_SECOND   = 8'hAA;
    localparam logic [4:0] WRITE_CYCLES = 5'h10;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_FIRST, SEQ_ARMED} seq_t;
    typedef enum logic [1:0] {OP_IDLE, OP_WRITE, OP_FL_WAIT, OP_FL_ACC} op_t;

endpackage

// File: hw/nvm_self_access_controller.sv
// module: axi4-lite register front end and sequencer for eeprom and flash self access
`timescale 1ns/1ps
`default_nettype none
module nvm_self_access_controller
    import nvm_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // axi4-lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // axi4-lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // axi4-lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // data eeprom array
    output logic [7:0]       eeAddr,
    output logic [7:0]       eeWrData,
    output logic             eeWrEn,
    input  wire logic [7:0]  eeRdData,
    // flash program array
    output logic [15:0]      flashAddr,
    output logic             flashRdEn,
    input  wire logic [15:0] flashRdData,
    // completion interrupt
    output logic             nvmIrq
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic isReg(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    function automatic logic isMapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= OFS_IRQ);
    endfunction

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] awAddr_r;
    logic       awHeld_r;
    logic [7:0] wByte_r;
    logic       wLane_r;
    logic       wHeld_r;
    logic       bvalid_r;
    logic [1:0] bresp_r;
    logic       rvalid_r;
    logic [1:0] rresp_r;
    logic [7:0] rByte_r;
    logic [7:0] addrLo_r;
    logic [7:0] addrHi_r;
    logic [7:0] valLo_r;
    logic [7:0] valHi_r;
    logic       pss_r;
    logic       permit_r;
    logic       doneFlag_r;
    logic       irqEn_r;
    logic       gate_r;
    logic       eeWrEn_r;
    logic       flashRdEn_r;
    logic [4:0] wrCnt_r;
    logic [4:0] wrCnt_nxt;
    op_t        opSt_r;
    op_t        opSt_nxt;
    logic       seqArmed;

    // ------------------------------------------------------------
    // write channel handshakes
    // ------------------------------------------------------------
    // address and data are parked separately so either may come first
    wire awTake = awvalid && awready;
    wire wTake  = wvalid && wready;
    wire wrDo   = awHeld_r && wHeld_r && !bvalid_r;
    wire arTake = arvalid && arready;

    assign awready = !awHeld_r && !bvalid_r;
    assign wready  = !wHeld_r && !bvalid_r;
    assign arready = !rvalid_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign rvalid  = rvalid_r;
    assign rresp   = rresp_r;
    assign rdata   = {24'h000000, rByte_r};

    // parked address
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            awHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
        end else if (awTake) begin
            awHeld_r <= 1'b1;
            awAddr_r <= awaddr;
        end else if (wrDo) begin
            awHeld_r <= 1'b0;
        end
    end

    // parked data; only the low lane carries register bits
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wHeld_r <= 1'b0;
            wByte_r <= 8'h00;
            wLane_r <= 1'b0;
        end else if (wTake) begin
            wHeld_r <= 1'b1;
            wByte_r <= wdata[7:0];
            wLane_r <= wstrb[0];
        end else if (wrDo) begin
            wHeld_r <= 1'b0;
        end
    end

    // write response, error for holes in the map
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (wrDo) begin
            bvalid_r <= 1'b1;
            bresp_r  <= isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register write selects
    // ------------------------------------------------------------
    wire wrLane   = wrDo && wLane_r;
    wire weAddrLo = wrLane && isReg(awAddr_r, OFS_ADDR_LO);
    wire weAddrHi = wrLane && isReg(awAddr_r, OFS_ADDR_HI);
    wire weValLo  = wrLane && isReg(awAddr_r, OFS_VAL_LO);
    wire weValHi  = wrLane && isReg(awAddr_r, OFS_VAL_HI);
    wire ctlWe    = wrLane && isReg(awAddr_r, OFS_CTRL);
    wire unlockWe = wrLane && isReg(awAddr_r, OFS_UNLOCK);
    wire irqWe    = wrLane && isReg(awAddr_r, OFS_IRQ);

    // ------------------------------------------------------------
    // operation start decode
    // ------------------------------------------------------------
    wire pssNew    = wByte_r[CTL_PSS];
    wire permitNew = wByte_r[CTL_PERMIT];
    wire opIdle    = (opSt_r == OP_IDLE);
    wire wrBit     = (opSt_r == OP_WRITE);
    wire rdBit     = (opSt_r == OP_FL_WAIT) || (opSt_r == OP_FL_ACC);
    // a program-space write request never reaches the write bit
    wire pgmWrDrop = ctlWe && wByte_r[CTL_WR] && pssNew;
    wire wrStart   = ctlWe && wByte_r[CTL_WR] && seqArmed && permitNew
                     && !pssNew && opIdle;
    wire rdStart   = ctlWe && wByte_r[CTL_RD] && opIdle && !wrStart;
    wire eeRdStart = rdStart && !pssNew;
    wire flRdStart = rdStart && pssNew;
    wire flLatch   = (opSt_r == OP_FL_ACC);
    wire doneSet   = wrBit && (wrCnt_r == 5'h00);
    wire doneClr   = irqWe && !wByte_r[IRQ_DONE];

    // ------------------------------------------------------------
    // unlock sequencer
    // ------------------------------------------------------------
    nvm_unlock_seq uSeq (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .access  (wrDo || arTake),
        .keyWr   (unlockWe),
        .key     (wByte_r),
        .busy    (wrBit),
        .armed   (seqArmed)
    );

    // ------------------------------------------------------------
    // operation sequencer
    // ------------------------------------------------------------
    // write timing ignores permit once running, so clearing it cannot cut a write short
    always_comb begin
        opSt_nxt  = opSt_r;
        wrCnt_nxt = wrCnt_r;
        case (opSt_r)
            OP_IDLE: begin
                if (wrStart) begin
                    opSt_nxt  = OP_WRITE;
                    wrCnt_nxt = WRITE_CYCLES - 5'h01;
                end else if (flRdStart) begin
                    opSt_nxt = OP_FL_WAIT;
                end
            end
            OP_WRITE: begin
                if (wrCnt_r == 5'h00) begin
                    opSt_nxt = OP_IDLE;
                end else begin
                    wrCnt_nxt = wrCnt_r - 5'h01;
                end
            end
            OP_FL_WAIT: begin
                opSt_nxt = OP_FL_ACC;
            end
            default: begin
                opSt_nxt = OP_IDLE;
            end
        endcase
    end

    // sequencer state
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            opSt_r  <= OP_IDLE;
            wrCnt_r <= 5'h00;
        end else begin
            opSt_r  <= opSt_nxt;
            wrCnt_r <= wrCnt_nxt;
        end
    end

    // array strobes: one cycle each, flash strobe marks the access slot
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            eeWrEn_r    <= 1'b0;
            flashRdEn_r <= 1'b0;
        end else begin
            eeWrEn_r    <= wrStart;
            flashRdEn_r <= (opSt_r == OP_FL_WAIT);
        end
    end

    assign eeWrEn    = eeWrEn_r;
    assign flashRdEn = flashRdEn_r;
    assign eeAddr    = addrLo_r;
    assign eeWrData  = valLo_r;
    assign flashAddr = {addrHi_r, addrLo_r};

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // address bytes
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            addrLo_r <= RST_BYTE;
            addrHi_r <= RST_BYTE;
        end else begin
            if (weAddrLo) addrLo_r <= wByte_r;
            if (weAddrHi) addrHi_r <= wByte_r;
        end
    end

    // value bytes: hardware load beats a software write in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            valLo_r <= RST_BYTE;
            valHi_r <= RST_BYTE;
        end else begin
            if (eeRdStart) valLo_r <= eeRdData;
            else if (flLatch) valLo_r <= flashRdData[7:0];
            else if (weValLo) valLo_r <= wByte_r;
            if (flLatch) valHi_r <= flashRdData[15:8];
            else if (weValHi) valHi_r <= wByte_r;
        end
    end

    // control bits: permit moves only on a software write
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pss_r    <= 1'b0;
            permit_r <= 1'b0;
        end else if (ctlWe) begin
            pss_r    <= pssNew;
            permit_r <= permitNew;
        end
    end

    // done flag: a completion in the clearing cycle still wins
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            doneFlag_r <= 1'b0;
            irqEn_r    <= 1'b0;
            gate_r     <= 1'b0;
        end else begin
            doneFlag_r <= doneSet || (doneFlag_r && !doneClr);
            if (irqWe) begin
                irqEn_r <= wByte_r[IRQ_EN];
                gate_r  <= wByte_r[IRQ_GATE];
            end
        end
    end

    // completion request needs both its own enable and the peripheral gate
    assign nvmIrq = doneFlag_r && irqEn_r && gate_r;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    wire [7:0] ctlView = {pss_r, 4'h0, permit_r, wrBit, rdBit};
    wire [7:0] irqView = {5'h00, gate_r, irqEn_r, doneFlag_r};
    wire [7:0] rdMux   =
        isReg(araddr, OFS_ADDR_LO) ? addrLo_r :
        isReg(araddr, OFS_ADDR_HI) ? addrHi_r :
        isReg(araddr, OFS_VAL_LO)  ? valLo_r  :
        isReg(araddr, OFS_VAL_HI)  ? valHi_r  :
        isReg(araddr, OFS_CTRL)    ? ctlView  :
        isReg(araddr, OFS_IRQ)     ? irqView  : 8'h00;

    // read data registered one cycle after the address is taken
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OKAY;
            rByte_r  <= 8'h00;
        end else if (arTake) begin
            rvalid_r <= 1'b1;
            rresp_r  <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            rByte_r  <= rdMux;
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    localparam int WrDoneLat = int'(WRITE_CYCLES) + 1;

    default clocking cbMain @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence flSlot;
        !flashRdEn ##1 !flashRdEn ##1 flashRdEn ##1 !flashRdEn;
    endsequence

    sequence wrRun;
        wrBit [*8];
    endsequence

    chk_ee_read_byte: assert property (
        eeRdStart |=> valLo_r == $past(eeRdData))
        else $error("eeprom byte not in value low next cycle");
    chk_value_hold: assert property (
        !eeRdStart && !flLatch && !weValLo |=> $stable(valLo_r))
        else $error("value low changed without cause");
    chk_wr_unlocked: assert property (
        $rose(wrBit) |-> $past(seqArmed) && $past(ctlWe))
        else $error("write began without unlock");
    chk_wr_permit: assert property (
        $rose(wrBit) |-> permit_r && !pss_r)
        else $error("write bit set with permit clear");
    chk_permit_sw_only: assert property (
        !$stable(permit_r) |-> $past(ctlWe))
        else $error("permit changed by hardware");
    chk_write_runs: assert property (
        wrStart |=> wrRun)
        else $error("write cycle cut short");
    chk_write_done: assert property (
        wrStart |-> ##WrDoneLat (doneFlag_r && !wrBit))
        else $error("done not set or write bit not cleared at end");
    chk_done_sticky: assert property (
        doneFlag_r && !doneClr |=> doneFlag_r)
        else $error("done flag cleared by hardware");
    chk_flash_slot: assert property (
        flRdStart |-> flSlot)
        else $error("flash access not in second cycle");
    chk_flash_word: assert property (
        flashRdEn |=> valLo_r == $past(flashRdData[7:0])
                      && valHi_r == $past(flashRdData[15:8]))
        else $error("flash word not latched");
    chk_pgm_wr_drop: assert property (
        pgmWrDrop && opIdle |=> !wrBit && !eeWrEn)
        else $error("program-space write not dropped");
    chk_irq_gate: assert property (
        doneSet && irqEn_r && gate_r && !irqWe |=> nvmIrq)
        else $error("gated completion request missing");

endmodule
`default_nettype wire

// File: hw/nvm_unlock_seq.sv
// module: two-key unlock sequencer gating the eeprom write start
`timescale 1ns/1ps
`default_nettype none
module nvm_unlock_seq
    import nvm_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // register traffic
    input  wire logic       access,
    input  wire logic       keyWr,
    input  wire logic [7:0] key,
    input  wire logic       busy,
    // result
    output logic            armed
);

    seq_t st_r;
    seq_t st_nxt;

    // ------------------------------------------------------------
    // sequence decode
    // ------------------------------------------------------------
    // any access steps the sequence; only the exact next key advances
    always_comb begin
        st_nxt = st_r;
        if (busy) begin
            st_nxt = SEQ_IDLE;
        end else if (access) begin
            case (st_r)
                SEQ_IDLE: begin
                    st_nxt = (keyWr && key == KEY_FIRST) ? SEQ_FIRST : SEQ_IDLE;
                end
                SEQ_FIRST: begin
                    st_nxt = (keyWr && key == KEY_SECOND) ? SEQ_ARMED : SEQ_IDLE;
                end
                default: begin
                    st_nxt = SEQ_IDLE;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_r <= SEQ_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // armed only for the one access that follows the second key
    assign armed = (st_r == SEQ_ARMED);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cbSeq @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    chk_unlock_arm: assert property (
        $rose(armed) |-> $past(st_r == SEQ_FIRST) && $past(keyWr) && $past(key) == KEY_SECOND)
        else $error("sequencer armed without the second key");
    chk_unlock_abort: assert property (
        armed && access |=> st_r == SEQ_IDLE)
        else $error("sequencer not idle after consuming access");
    chk_unlock_busy: assert property (
        busy |=> st_r == SEQ_IDLE)
        else $error("unlock accepted while a write runs");

endmodule
`default_nettype wire
